/* File: src/sdc_map.svh */
// offsets, field positions, reset values and timing counts of the back end
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// ==========================================================================
// register byte offsets
`define SDC_CFG1_OFS      8'h00
`define SDC_CFG2_OFS      8'h04
`define SDC_CFG3_OFS      8'h08
`define SDC_STAT_OFS      8'h0C
`define SDC_DATA_OFS      8'h10

// ==========================================================================
// field positions
`define SDC_CFG1_DR_LSB   0
`define SDC_CFG1_CLKOE    5
`define SDC_CFG2_REFHI    4
`define SDC_CFG3_REFBUF   7
`define SDC_STAT_RDY      0
`define SDC_STAT_SETTLED  1
`define SDC_STAT_CLKSRC   2
`define SDC_STAT_CNT_LSB  8

// ==========================================================================
// reset values
`define SDC_CFG1_RST      8'h06
`define SDC_CFG2_RST      8'h00
`define SDC_CFG3_RST      8'h00

// ==========================================================================
// timing: reference clock and internal oscillator in kHz
`define SDC_REF_KHZ       100000
`define SDC_OSC_KHZ       2048
`define SDC_OSC_STEP      (2 * `SDC_OSC_KHZ)
`define SDC_MCLK_PER_MOD  2
`define SDC_SETTLE_CONV   3
`define SDC_MIN_RATIO     16
`define SDC_DR_MAX        3'h6

`endif

/* File: src/sdc_pkg.sv */
// types shared by the decimator back end
package sdc_pkg;
   localparam int NCH = 4;

   // avalon request from the bus master
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } sdc_bus_req_type;

   // avalon answer to the bus master
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } sdc_bus_rsp_type;

   // tri-state clock pin
   typedef struct packed {
      logic o;
      logic oe;
   } sdc_pin_type;

   // master clock source
   typedef enum logic {SDC_SRC_EXT, SDC_SRC_OSC} sdc_src_type;
endpackage

/* File: src/sdc_modulator.sv */
// second-order delta-sigma modulator, one per channel
module sdc_modulator
(
   // clock and control
   input  wire logic               ref_clk,
   input  wire logic               reset,
   input  wire logic               clk_en,
   input  wire logic               mod_tick,
   // sample in, bit stream out
   input  wire logic signed [15:0] sample,
   output logic                    bit_out
);
   import sdc_pkg::*;

   logic signed [23:0] int1_q, int1_d;
   logic signed [23:0] int2_q, int2_d;
   logic               bit_q, bit_d;
   logic signed [23:0] fb;

   // two integrators with one-bit feedback
   always_comb
   begin
      fb     = bit_q ? 24'sh008000 : -24'sh008000;
      int1_d = int1_q;
      int2_d = int2_q;
      bit_d  = bit_q;
      if (mod_tick)
      begin
         int1_d = int1_q + 24'(sample) - fb;
         int2_d = int2_q + int1_d - fb;
         bit_d  = ~int2_d[23];
      end
   end

   // state registers
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         int1_q <= '0;
         int2_q <= '0;
         bit_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         int1_q <= int1_d;
         int2_q <= int2_d;
         bit_q  <= bit_d;
      end
   end

   assign bit_out = bit_q;
endmodule

/* File: src/sdc_sinc3.sv */
// third-order sinc decimator for one channel
module sdc_sinc3
(
   // clock and control
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic        flush,
   input  wire logic        mod_tick,
   input  wire logic        dump,
   input  wire logic [2:0]  rate,
   // stream in, words out
   input  wire logic        bit_in,
   output logic [23:0]      word,
   output logic             valid
);
   import sdc_pkg::*;

   logic signed [31:0] i1_q, i1_d, i2_q, i2_d, i3_q, i3_d;
   logic signed [31:0] d1_q, d1_d, d2_q, d2_d, d3_q, d3_d;
   logic signed [31:0] c1, c2, c3, scaled;
   logic [23:0]        word_q, word_d;
   logic               valid_d, valid_q;
   logic [4:0]         shift;

   // integrators at the modulator rate, combs at the output rate
   always_comb
   begin
      i1_d    = i1_q;
      i2_d    = i2_q;
      i3_d    = i3_q;
      d1_d    = d1_q;
      d2_d    = d2_q;
      d3_d    = d3_q;
      word_d  = word_q;
      valid_d = 1'b0;
      shift   = 5'(18 - 3 * rate);
      c1      = '0;
      c2      = '0;
      c3      = '0;
      scaled  = '0;
      if (mod_tick)
      begin
         i1_d = i1_q + (bit_in ? 32'sh1 : -32'sh1);
         i2_d = i2_q + i1_d;
         i3_d = i3_q + i2_d;
      end
      if (dump)
      begin
         c1      = i3_d - d1_q;
         c2      = c1 - d2_q;
         c3      = c2 - d3_q;
         d1_d    = i3_d;
         d2_d    = c1;
         d3_d    = c2;
         scaled  = c3 <<< shift;                 // full scale at 2^30
         word_d  = (scaled >= 32'sh40000000) ? 24'h7FFFFF : scaled[30:7];
         valid_d = 1'b1;
      end
   end

   // state registers; flush restarts the filter
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         {i1_q, i2_q, i3_q, d1_q, d2_q, d3_q} <= '0;
         word_q  <= '0;
         valid_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (flush)
         begin
            {i1_q, i2_q, i3_q, d1_q, d2_q, d3_q} <= '0;
            valid_q <= 1'b0;
         end
         else
         begin
            i1_q    <= i1_d;
            i2_q    <= i2_d;
            i3_q    <= i3_d;
            d1_q    <= d1_d;
            d2_q    <= d2_d;
            d3_q    <= d3_d;
            word_q  <= word_d;
            valid_q <= valid_d;
         end
      end
   end

   assign word  = word_q;
   assign valid = valid_q;
endmodule

/* File: src/sdc_top.sv */
// multichannel sinc3 decimator, clock source and reference control
//
// Functional notes
// [RQ1] modulator rate is master clock over two
// [RQ2] each channel has its own second-order modulator
// [RQ3] select low: clock pin is an input
// [RQ4] select high: oscillator, pin 3-state or driven
// [RQ5] ratio is modulator rate over data rate
// [RQ6] per-channel sinc3 filter, cube of comb/integrator
// [RQ7] output settles after three full conversions
// [RQ8] one data-rate code sets every channel
// [RQ9] notches at data rate, scale with clock
// [RQ10] reference high select picks 4 V else 2.4 V
// [RQ11] host keeps 2.4 V on 3 V supply
// [RQ12] buffer power bit; off frees positive reference pin
// [RQ13] power-up with reference buffer off
// [RQ14] host may stop external clock in power-down
// [RQ15] internal oscillator gives 2.048 MHz master clock
// [RQ16] one shared decimation counter for all channels
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`include "sdc_map.svh"

module sdc_top
(
   // clock, reset, enable
   input  wire logic                      ref_clk,
   input  wire logic                      reset,
   input  wire logic                      clk_en,
   // register bus
   input  wire sdc_pkg::sdc_bus_req_type  bus_req,
   output sdc_pkg::sdc_bus_rsp_type       bus_rsp,
   // clock pins
   input  wire logic                      clock_source_select,
   input  wire logic                      clk_pin_i,
   output sdc_pkg::sdc_pin_type           clk_pin,
   // channel samples and words
   input  wire logic [sdc_pkg::NCH-1:0][15:0] ch_sample,
   output logic [sdc_pkg::NCH-1:0][23:0]  conv_data,
   output logic                           conv_valid,
   output logic                           conv_settled,
   // reference control
   output logic                           reference_high_select,
   output logic                           reference_buffer_power,
   output logic                           positive_reference_ext
);
   import sdc_pkg::*;

   // =======================================================================
   // register state
   logic [7:0]  cfg1_q, cfg1_d;
   logic [7:0]  cfg2_q, cfg2_d;
   logic [7:0]  cfg3_q, cfg3_d;
   logic        rdy_q, rdy_d;
   logic        ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic        flush_q, flush_d;
   logic        access;
   logic [2:0]  rate;

   // =======================================================================
   // clock generation state
   logic [16:0] osc_acc_q, osc_acc_d;
   logic        osc_q, osc_d;
   logic        pin_q, pin_d;
   logic        mclk_tick;
   logic        half_q, half_d;
   logic        mod_tick;
   sdc_src_type src;

   // =======================================================================
   // decimation state
   logic [9:0]  dec_cnt_q, dec_cnt_d;
   logic [9:0]  ratio_m1;
   logic        dump;
   logic [1:0]  conv_cnt_q, conv_cnt_d;
   logic [NCH-1:0]        mod_bit;
   logic [NCH-1:0]        ch_valid;
   logic [NCH-1:0][23:0]  ch_word;

   // =======================================================================
   // internal oscillator as phase accumulator
   // average rate is exact; each edge may jitter by one clock
   always_comb
   begin
      osc_acc_d = osc_acc_q + 17'(`SDC_OSC_STEP);    // see [RQ15]
      osc_d     = osc_q;
      if (osc_acc_d >= 17'(`SDC_REF_KHZ))
      begin
         osc_acc_d = osc_acc_d - 17'(`SDC_REF_KHZ);
         osc_d     = ~osc_q;                         // see [RQ15]
      end
   end

   // master clock tick from the selected source
   always_comb
   begin
      src   = clock_source_select ? SDC_SRC_OSC : SDC_SRC_EXT;
      pin_d = clk_pin_i;
      case (src)
         SDC_SRC_EXT: mclk_tick = clk_pin_i & ~pin_q;  // see [RQ3]
         SDC_SRC_OSC: mclk_tick = osc_d & ~osc_q;      // see [RQ4]
         default:     mclk_tick = 1'b0;
      endcase
      half_d   = mclk_tick ? ~half_q : half_q;
      mod_tick = mclk_tick & half_q;                   // see [RQ1]
   end

   // clock generation registers
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         osc_acc_q <= '0;
         osc_q     <= 1'b0;
         pin_q     <= 1'b0;
         half_q    <= 1'b0;
      end
      else if (clk_en)
      begin
         osc_acc_q <= osc_acc_d;
         osc_q     <= osc_d;
         pin_q     <= pin_d;
         half_q    <= half_d;
      end
   end

   // clock pin drive
   always_comb
   begin
      clk_pin.o  = osc_q;
      clk_pin.oe = clock_source_select & cfg1_q[`SDC_CFG1_CLKOE]; // see [RQ4]
   end

   // =======================================================================
   // shared decimation counter
   always_comb
   begin
      // code 7 has no ratio of its own and runs as code 6
      rate = (cfg1_q[2:0] > `SDC_DR_MAX) ? `SDC_DR_MAX
                                         : cfg1_q[2:0]; // see [RQ8]
      ratio_m1 = 10'((`SDC_MIN_RATIO << rate) - 1);   // see [RQ5]
      dump      = mod_tick & (dec_cnt_q == ratio_m1); // see [RQ16]
      dec_cnt_d = dec_cnt_q;
      if (mod_tick)
         dec_cnt_d = dump ? 10'h000 : dec_cnt_q + 10'h001;
      conv_cnt_d = conv_cnt_q;
      if (ch_valid[0] && conv_cnt_q != 2'(`SDC_SETTLE_CONV))
         conv_cnt_d = conv_cnt_q + 2'h1;              // see [RQ7]
   end

   // decimation registers; CFG1 write restarts
   // a new ratio would mix two rates in the combs, so the count restarts
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         dec_cnt_q  <= '0;
         conv_cnt_q <= '0;
      end
      else if (clk_en)
      begin
         if (flush_q)
         begin
            dec_cnt_q  <= '0;
            conv_cnt_q <= '0;
         end
         else
         begin
            dec_cnt_q  <= dec_cnt_d;
            conv_cnt_q <= conv_cnt_d;
         end
      end
   end

   // =======================================================================
   // per-channel modulator and filter
   generate
      for (genvar ch = 0; ch < NCH; ch++)
      begin : g_ch
         // own modulator for each channel
         sdc_modulator u_mod                          // see [RQ2]
         (
            .ref_clk  (ref_clk),
            .reset    (reset),
            .clk_en   (clk_en),
            .mod_tick (mod_tick),
            .sample   (ch_sample[ch]),
            .bit_out  (mod_bit[ch])
         );

         // sinc3 filter, notches follow the modulator tick
         sdc_sinc3 u_flt                              // see [RQ6] [RQ9]
         (
            .ref_clk  (ref_clk),
            .reset    (reset),
            .clk_en   (clk_en),
            .flush    (flush_q),
            .mod_tick (mod_tick),
            .dump     (dump),
            .rate     (rate),
            .bit_in   (mod_bit[ch]),
            .word     (ch_word[ch]),
            .valid    (ch_valid[ch])
         );
      end
   endgenerate

   // conversion outputs
   always_comb
   begin
      conv_data    = ch_word;
      conv_valid   = ch_valid[0];
      conv_settled = (conv_cnt_q == 2'(`SDC_SETTLE_CONV)); // see [RQ7]
   end

   // =======================================================================
   // avalon slave: one wait cycle per access
   // reads are captured on the first edge and shown in the wait-free
   // cycle; writes land on the edge that sees waitrequest low, so a
   // register never moves ahead of the answer the master takes
   always_comb
   begin
      access  = (bus_req.read | bus_req.write) & ~ack_q;
      ack_d   = access;
      cfg1_d  = cfg1_q;
      cfg2_d  = cfg2_q;
      cfg3_d  = cfg3_q;
      rdata_d = rdata_q;
      flush_d = 1'b0;
      rdy_d   = rdy_q;
      if (ack_q && bus_req.write)
      begin
         case (bus_req.address)
            `SDC_CFG1_OFS:
            begin
               cfg1_d  = bus_req.writedata[7:0];
               flush_d = 1'b1;
            end
            `SDC_CFG2_OFS: cfg2_d = bus_req.writedata[7:0];
            `SDC_CFG3_OFS: cfg3_d = bus_req.writedata[7:0];
            default:       cfg1_d = cfg1_q;
         endcase
      end
      if (access && bus_req.read)
      begin
         rdata_d = 32'h00000000;
         case (bus_req.address)
            `SDC_CFG1_OFS: rdata_d[7:0] = cfg1_q;
            `SDC_CFG2_OFS: rdata_d[7:0] = cfg2_q;
            `SDC_CFG3_OFS: rdata_d[7:0] = cfg3_q;
            `SDC_STAT_OFS:
            begin
               rdata_d[`SDC_STAT_RDY]     = rdy_q;
               rdata_d[`SDC_STAT_SETTLED] = conv_settled;
               rdata_d[`SDC_STAT_CLKSRC]  = clock_source_select;
               rdata_d[`SDC_STAT_CNT_LSB +: 2] = conv_cnt_q;
               rdy_d = 1'b0;                      // read clears ready
            end
            default:
            begin
               for (int i = 0; i < NCH; i++)
                  if (bus_req.address == 8'(`SDC_DATA_OFS + 4 * i))
                     rdata_d[23:0] = ch_word[i];
            end
         endcase
      end
      if (ch_valid[0])
         rdy_d = 1'b1;                            // new word wins over clear
   end

   // register bank
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cfg1_q  <= `SDC_CFG1_RST;
         cfg2_q  <= `SDC_CFG2_RST;
         cfg3_q  <= `SDC_CFG3_RST;                // see [RQ13]
         rdy_q   <= 1'b0;
         ack_q   <= 1'b0;
         rdata_q <= '0;
         flush_q <= 1'b0;
      end
      else if (clk_en)
      begin
         cfg1_q  <= cfg1_d;
         cfg2_q  <= cfg2_d;
         cfg3_q  <= cfg3_d;
         rdy_q   <= rdy_d;
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
         flush_q <= flush_d;
      end
   end

   // bus answer and reference control
   always_comb
   begin
      bus_rsp.readdata       = rdata_q;
      bus_rsp.waitrequest    = ~ack_q;
      reference_high_select  = cfg2_q[`SDC_CFG2_REFHI];   // see [RQ10]
      reference_buffer_power = cfg3_q[`SDC_CFG3_REFBUF];  // see [RQ12]
      positive_reference_ext = ~cfg3_q[`SDC_CFG3_REFBUF]; // see [RQ12]
   end
endmodule

/* File: sim/sdc_ext_clk_model.sv */
// external master clock source and channel stimulus
module sdc_ext_clk_model
#(
   parameter int HALF = 10
)
(
   // clock and control
   input  wire logic                     ref_clk,
   input  wire logic                     run,
   // pin drive and channel inputs
   output logic                          clk_out,
   output logic                          drive,
   output logic [sdc_pkg::NCH-1:0][15:0] sample
);
   timeunit 1ns;
   timeprecision 1ns;
   import sdc_pkg::*;
   int cnt = 0;
   initial clk_out = 1'b0;
   // toggle every HALF cycles, stand still when stopped
   always @(posedge ref_clk)
      if (run && cnt == HALF - 1)
      begin
         cnt <= 0;
         clk_out <= ~clk_out;
      end
      else if (run)
         cnt <= cnt + 1;
   // pin driven only while the clock runs
   assign drive = run;
   // fixed levels per channel, channels 0 and 2 alike
   assign sample = {16'h1000, 16'h4000, 16'hC000, 16'h4000};
endmodule

/* File: sim/sdc_top_monitor.sv */
// checker on the ports of the decimator back end
module sdc_top_monitor
(
   // clock and reset
   input wire logic                      ref_clk,
   input wire logic                      reset,
   // register bus
   input wire sdc_pkg::sdc_bus_req_type  bus_req,
   input wire sdc_pkg::sdc_bus_rsp_type  bus_rsp,
   // clock pin
   input wire logic                      clock_source_select,
   input wire sdc_pkg::sdc_pin_type      clk_pin,
   // words and reference
   input wire logic [sdc_pkg::NCH-1:0][23:0] conv_data,
   input wire logic                      conv_valid,
   input wire logic                      conv_settled,
   input wire logic                      reference_high_select,
   input wire logic                      reference_buffer_power,
   input wire logic                      positive_reference_ext
);
   timeunit 1ns;
   timeprecision 1ns;
   import sdc_pkg::*;
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic       acc;
   logic       cfg1_wr_q;
   // accepted write cycle
   assign acc = bus_req.write && !bus_rsp.waitrequest;
   // conversions since restart, saturating at three
   always_comb
   begin
      cnt_d = cnt_q;
      if (conv_valid && cnt_q != 2'h3)
         cnt_d = cnt_q + 2'h1;
      if (reset || cfg1_wr_q)
         cnt_d = 2'h0;
   end
   // the filters restart one cycle after the write lands
   always_ff @(posedge ref_clk)
   begin
      cnt_q     <= cnt_d;
      cfg1_wr_q <= acc && bus_req.address == 8'h00;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ==================================================
   // properties
   property p_clk_in;
      clk_pin.oe |-> clock_source_select;
   endproperty
   a_clk_in: assert property (p_clk_in)
      else $error("clock pin driven with select low");
   property p_clk_oe;
      $changed(clk_pin.oe) |-> $changed(clock_source_select)
         || $past(acc && bus_req.address == 8'h00);
   endproperty
   a_clk_oe: assert property (p_clk_oe)
      else $error("clock pin enable moved without cause");
   property p_osc;
      clock_source_select && $rose(clk_pin.o) |->
         ##[48:50] ($rose(clk_pin.o) || !clock_source_select);
   endproperty
   a_osc: assert property (p_osc)
      else $error("oscillator period off");
   property p_valid;
      conv_valid |=> !conv_valid [*8];
   endproperty
   a_valid: assert property (p_valid)
      else $error("conversion pulses too close");
   property p_data;
      $changed(conv_data) |-> conv_valid;
   endproperty
   a_data: assert property (p_data)
      else $error("channel words moved outside a pulse");
   property p_ref_ext;
      positive_reference_ext != reference_buffer_power;
   endproperty
   a_ref_ext: assert property (p_ref_ext)
      else $error("reference pin mode wrong");
   property p_ref_hi;
      $changed(reference_high_select) |->
         $past(acc && bus_req.address == 8'h04);
   endproperty
   a_ref_hi: assert property (p_ref_hi)
      else $error("reference level moved without write");
   property p_ref_buf;
      $changed(reference_buffer_power) |->
         $past(acc && bus_req.address == 8'h08);
   endproperty
   a_ref_buf: assert property (p_ref_buf)
      else $error("buffer power moved without write");
   property p_settle;
      conv_settled |-> cnt_q + conv_valid >= 3;
   endproperty
   a_settle: assert property (p_settle)
      else $error("settled before three conversions");
endmodule

bind sdc_top sdc_top_monitor u_mon
(
   .ref_clk                (ref_clk),
   .reset                  (reset),
   .bus_req                (bus_req),
   .bus_rsp                (bus_rsp),
   .clock_source_select    (clock_source_select),
   .clk_pin                (clk_pin),
   .conv_data              (conv_data),
   .conv_valid             (conv_valid),
   .conv_settled           (conv_settled),
   .reference_high_select  (reference_high_select),
   .reference_buffer_power (reference_buffer_power),
   .positive_reference_ext (positive_reference_ext)
);

/* File: sim/sinc3_decimator_clock_ref_ctrl_tb.sv */
// self-checking bench for the decimator back end
`include "sdc_map.svh"
module sinc3_decimator_clock_ref_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sdc_pkg::*;
   logic ref_clk = 1'b0;
   logic reset, clk_en, sel, ext_run, ext_clk, ext_drv, pin_lvl, o_old;
   logic pin_prev = 1'b0;
   sdc_bus_req_type      bus_req;
   sdc_bus_rsp_type      bus_rsp;
   sdc_pin_type          clk_pin;
   logic [NCH-1:0][15:0] ch_sample;
   logic [NCH-1:0][23:0] conv_data;
   logic                 conv_valid, conv_settled, ref_hi, buf_pwr, ref_ext;
   logic [31:0]          rd;
   int                   err_total = 0;
   int                   cmp_count = 0;
   int                   n, c;
   always #5 ref_clk = ~ref_clk;
   // pin level from every party's enable, inverse of last when undriven
   assign pin_lvl = clk_pin.oe ? clk_pin.o : ext_drv ? ext_clk : ~pin_prev;
   always @(posedge ref_clk)
      pin_prev <= pin_lvl;
   sdc_top dut
   (
      .ref_clk (ref_clk), .reset (reset), .clk_en (clk_en),
      .bus_req (bus_req), .bus_rsp (bus_rsp),
      .clock_source_select (sel), .clk_pin_i (pin_lvl), .clk_pin (clk_pin),
      .ch_sample (ch_sample), .conv_data (conv_data),
      .conv_valid (conv_valid), .conv_settled (conv_settled),
      .reference_high_select (ref_hi), .reference_buffer_power (buf_pwr),
      .positive_reference_ext (ref_ext)
   );
   sdc_ext_clk_model #(.HALF (10)) u_ext
   (
      .ref_clk (ref_clk), .run (ext_run), .clk_out (ext_clk),
      .drive (ext_drv), .sample (ch_sample)
   );
   // ==================================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon cycle, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      n = 0;
      bus_req <= '{a, ~wr, wr, d};
      @(posedge ref_clk);
      while (bus_rsp.waitrequest !== 1'b0 && n < 100)
      begin
         n++;
         @(posedge ref_clk);
      end
      chk(n < 100, 1);
      rd = bus_rsp.readdata;
      bus_req <= '{a, 1'b0, 1'b0, d};
      @(posedge ref_clk);
   endtask
   // cycles until the next conversion pulse
   task automatic wait_valid();
      c = 0;
      @(posedge ref_clk);
      while (conv_valid !== 1'b1 && c < 50000)
      begin
         c++;
         @(posedge ref_clk);
      end
   endtask
   task automatic test_done();
      $display("errors %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==================================================
   // tests
   initial
   begin
      reset = 1'b1;
      clk_en = 1'b1;
      sel = 1'b0;
      ext_run = 1'b1;
      bus_req = '0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      bus(0, `SDC_CFG1_OFS, 0);
      chk(rd, 32'h06);
      bus(0, `SDC_CFG3_OFS, 0);
      chk(rd, 0);
      chk({ref_hi, buf_pwr, ref_ext}, 3'b001);
      bus(0, 8'h40, 0);
      chk(rd, 0);
      // 4 V only while a 5 V supply is assumed, then back to 2.4 V
      bus(1, `SDC_CFG2_OFS, 32'h10);
      chk(ref_hi, 1);
      bus(0, `SDC_CFG2_OFS, 0);
      chk(rd, 32'h10);
      bus(1, `SDC_CFG2_OFS, 0);
      chk(ref_hi, 0);
      bus(1, `SDC_CFG3_OFS, 32'h80);
      chk({buf_pwr, ref_ext}, 2'b10);
      bus(1, `SDC_CFG3_OFS, 0);
      chk(ref_ext, 1);
      // clock pin and oscillator
      bus(1, `SDC_CFG1_OFS, 32'h20);
      chk(clk_pin.oe, 0);
      ext_run <= 1'b0;
      sel <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(clk_pin.oe, 1);
      n = 0;
      o_old = clk_pin.o;
      repeat (4883)
      begin
         @(posedge ref_clk);
         if (clk_pin.o === 1'b1 && o_old === 1'b0)
            n++;
         o_old = clk_pin.o;
      end
      chk(n >= 99 && n <= 101, 1);
      wait_valid();
      wait_valid();
      chk(c >= 1560 && c <= 1564, 1);
      bus(1, `SDC_CFG1_OFS, 0);
      chk(clk_pin.oe, 0);
      sel <= 1'b0;
      ext_run <= 1'b1;
      // conversion period for data-rate codes 0 to 2, external clock
      for (int dr = 0; dr < 3; dr++)
      begin
         bus(1, `SDC_CFG1_OFS, dr);
         wait_valid();
         wait_valid();
         chk(c, (640 << dr) - 1);
      end
      // settling after a restart
      bus(1, `SDC_CFG1_OFS, 0);
      chk(conv_settled, 0);
      wait_valid();
      wait_valid();
      chk(conv_settled, 0);
      wait_valid();
      @(posedge ref_clk);
      chk(conv_settled, 1);
      bus(0, `SDC_STAT_OFS, 0);
      chk(rd & 32'h306, 32'h302);
      chk(conv_data[0] === conv_data[2], 1);
      chk($signed(conv_data[0]) > $signed(conv_data[3]), 1);
      chk($signed(conv_data[3]) > 0, 1);
      chk($signed(conv_data[1]) < 0, 1);
      bus(0, `SDC_DATA_OFS + 8'h04, 0);
      chk(rd[23], 1);
      test_done();
   end
   // watchdog
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      err_total++;
      test_done();
   end
endmodule
